/* verilog/step_seq_pkg.sv */
`default_nettype none

package step_seq_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, word aligned)
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] ELAPSED_OFS = 12'h008;
  localparam logic [11:0] REF_BASE = 12'h040;
  localparam logic [11:0] TIME_BASE = 12'h080;
  localparam logic [11:0] RAMP_BASE = 12'h0C0;
  localparam logic [1:0] REGION_CTRL = 2'h0;
  localparam logic [1:0] REGION_REF = 2'h1;
  localparam logic [1:0] REGION_TIME = 2'h2;
  localparam logic [1:0] REGION_RAMP = 2'h3;
  localparam int REGION_LSB = 6;
  localparam int INDEX_LSB = 2;
  localparam int STATUS_STATE_LSB = 4;

  // ---------------------------------------------------------------
  // Modes, control fields, reset values
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EOC_STOP = 2'b00,
    EOC_HOLD = 2'b01,
    EOC_REPEAT = 2'b10
  } eoc_mode_t;

  // Bit 0 route, bits 2:1 end mode, bit 3 unit, bit 4 power, bit 5 stop
  typedef struct packed {
    logic ret_stop;
    logic ret_pwr;
    logic unit_hours;
    logic [1:0] mode;
    logic route_volt;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = 6'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10,
    ST_PWR = 2'b11
  } seq_state_t;

  localparam logic [3:0] LAST_STEP = 4'hF;
  localparam logic [15:0] REF_FULL_SCALE = 16'h03E8;
  localparam logic [15:0] TIME_RST = 16'h0000;
  localparam logic [1:0] RAMP_RST = 2'h0;

  // ---------------------------------------------------------------
  // Timing: tick is one tenth of the selected unit
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DIV_W = 21;
  localparam logic [11:0] TICKS_PER_HOUR_TICK = 12'h0E10;

endpackage

`default_nettype wire

/* verilog/step_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module step_sequencer
  import step_seq_pkg::*;
#(
  parameter int unsigned TENTH_S_CYCLES = TICK_CYCLES
) (
  input wire logic i_clk, // 20 MHz system clock
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [11:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error
  input wire logic i_run_cmd, // Run command pulse
  input wire logic i_stop_cmd, // Stop command pulse, wins over run
  input wire logic i_power_fail, // High while supply is lost
  output logic [15:0] o_freq_set, // Speed, tenths of percent
  output logic o_reverse, // Reverse direction
  output logic [1:0] o_ramp_sel, // Ramp time set
  output logic [15:0] o_volt_set, // Signed voltage, tenths of percent
  output logic [3:0] o_step, // Current step
  output logic o_running // Sequence active
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  ctrl_t ctrl, next_ctrl;
  logic [15:0] ref_mem [16];
  logic [15:0] time_mem [16];
  logic [1:0] ramp_mem [16];
  seq_state_t state, next_state, pl_state, next_pl_state;
  logic [3:0] step, next_step, pl_step, next_pl_step;
  logic [15:0] elapsed, next_elapsed, pl_elapsed, next_pl_elapsed;
  logic [DIV_W-1:0] pre_cnt, next_pre_cnt;
  logic [11:0] hr_cnt, next_hr_cnt;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [15:0] next_freq, next_volt;
  logic next_rev, next_running;
  logic [1:0] region;
  logic [3:0] idx;
  logic access, wr_ok, wr_ref, wr_time, wr_ramp;
  logic tick_s, tick, pass_end, step_done;
  logic [15:0] cur_ref, cur_time, mag;

  assign region = i_paddr[REGION_LSB+1:REGION_LSB];
  assign idx = i_paddr[REGION_LSB-1:INDEX_LSB];
  assign cur_ref = ref_mem[step];
  assign cur_time = time_mem[step];

  // ---------------------------------------------------------------
  // APB slave: one wait state, so pready rises in the second access cycle
  // ---------------------------------------------------------------
  always_comb begin
    access = i_psel && i_penable && !o_pready;
    next_pready = access;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_ctrl = ctrl;
    wr_ok = 1'b0;
    if (access) begin
      if (i_paddr[11:8] != 4'h0 || i_paddr[1:0] != 2'h0) begin
        next_pslverr = 1'b1;
      end else if (region == REGION_CTRL) begin
        unique case (i_paddr[REGION_LSB-1:0])
          CTRL_OFS[5:0]: begin
            next_prdata = {26'h000_0000, ctrl};
            if (i_pwrite) begin
              next_ctrl = ctrl_t'(i_pwdata[5:0]);
            end
          end
          STATUS_OFS[5:0]: begin
            next_prdata = {26'h000_0000, state, step};
            next_pslverr = i_pwrite;
          end
          ELAPSED_OFS[5:0]: begin
            next_prdata = {16'h0000, elapsed};
            next_pslverr = i_pwrite;
          end
          default: next_pslverr = 1'b1;
        endcase
      end else begin
        wr_ok = i_pwrite;
        unique case (region)
          REGION_REF: next_prdata = {16'h0000, ref_mem[idx]};
          REGION_TIME: next_prdata = {16'h0000, time_mem[idx]};
          default: next_prdata = {30'h0000_0000, ramp_mem[idx]};
        endcase
      end
    end
    wr_ref = wr_ok && region == REGION_REF;
    wr_time = wr_ok && region == REGION_TIME;
    wr_ramp = wr_ok && region == REGION_RAMP;
  end

  // Bus registers; read data is latched so it stands with pready
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl <= CTRL_RST;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------
  // Step table, one entry per generate iteration
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 16; g++) begin : g_step
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        ref_mem[g] <= 16'h0000;
        time_mem[g] <= TIME_RST;
        ramp_mem[g] <= RAMP_RST;
      end else if (idx == 4'(g)) begin
        if (wr_ref) begin
          ref_mem[g] <= i_pwdata[15:0];
        end
        if (wr_time) begin
          time_mem[g] <= i_pwdata[15:0];
        end
        if (wr_ramp) begin
          ramp_mem[g] <= i_pwdata[1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Tick divider: tenth second, and tenth hour as 3600 of those
  // ---------------------------------------------------------------
  always_comb begin
    tick_s = pre_cnt == DIV_W'(TENTH_S_CYCLES - 1);
    next_pre_cnt = tick_s ? '0 : pre_cnt + 1'b1;
    next_hr_cnt = hr_cnt;
    if (tick_s) begin
      next_hr_cnt = (hr_cnt == TICKS_PER_HOUR_TICK - 1'b1) ? 12'h000 : hr_cnt + 1'b1;
    end
    tick = ctrl.unit_hours ? (tick_s && hr_cnt == TICKS_PER_HOUR_TICK - 1'b1)
                           : tick_s;
    // Restart timing whenever not running so the first step after a start gets a full tick; later steps in a run do not restart it
    if (state != ST_RUN) begin
      next_pre_cnt = '0;
      next_hr_cnt = 12'h000;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_cnt <= '0;
      hr_cnt <= 12'h000;
    end else begin
      pre_cnt <= next_pre_cnt;
      hr_cnt <= next_hr_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer; supply loss outranks stop, stop outranks run
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_step = step;
    next_elapsed = elapsed;
    next_pl_state = pl_state;
    next_pl_step = pl_step;
    next_pl_elapsed = pl_elapsed;
    step_done = state == ST_RUN && elapsed >= cur_time;
    pass_end = step_done && step == LAST_STEP && !i_power_fail && !i_stop_cmd;
    if (i_power_fail && state != ST_PWR) begin
      next_state = ST_PWR;
      next_pl_state = state;
      next_pl_step = step;
      next_pl_elapsed = elapsed;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (i_run_cmd && !i_stop_cmd) begin
            next_state = ST_RUN;
            if (!ctrl.ret_stop) begin
              next_step = 4'h0;
              next_elapsed = 16'h0000;
            end
          end
        end
        ST_RUN: begin
          if (i_stop_cmd) begin
            next_state = ST_IDLE;
          end else if (step_done) begin
            next_elapsed = 16'h0000;
            if (step != LAST_STEP) begin
              next_step = step + 4'h1;
            end else if (ctrl.route_volt) begin
              next_step = 4'h0;
            end else begin
              unique case (ctrl.mode)
                EOC_HOLD: begin
                  next_state = ST_HOLD;
                  next_elapsed = elapsed;
                end
                EOC_REPEAT: next_step = 4'h0;
                default: begin
                  next_state = ST_IDLE;
                  next_step = 4'h0;
                end
              endcase
            end
          end else if (tick) begin
            next_elapsed = elapsed + 16'h0001;
          end
        end
        ST_HOLD: begin
          if (i_stop_cmd) begin
            next_state = ST_IDLE;
          end
        end
        ST_PWR: begin
          if (!i_power_fail) begin
            if (ctrl.ret_pwr) begin
              next_state = pl_state;
              next_step = pl_step;
              next_elapsed = pl_elapsed;
            end else begin
              next_state = (pl_state == ST_IDLE) ? ST_IDLE : ST_RUN;
              next_step = 4'h0;
              next_elapsed = 16'h0000;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      step <= 4'h0;
      elapsed <= 16'h0000;
      pl_state <= ST_IDLE;
      pl_step <= 4'h0;
      pl_elapsed <= 16'h0000;
    end else begin
      state <= next_state;
      step <= next_step;
      elapsed <= next_elapsed;
      pl_state <= next_pl_state;
      pl_step <= next_pl_step;
      pl_elapsed <= next_pl_elapsed;
    end
  end

  // ---------------------------------------------------------------
  // Setpoint outputs, registered; speed, reverse and voltage zero whenever the sequence is inactive
  // ---------------------------------------------------------------
  always_comb begin
    next_running = state == ST_RUN || state == ST_HOLD;
    mag = cur_ref[15] ? 16'(-cur_ref) : cur_ref;
    if (mag > REF_FULL_SCALE) begin
      mag = REF_FULL_SCALE; // Clip out-of-range entries to full scale for the speed output
    end
    next_freq = (next_running && !ctrl.route_volt) ? mag : 16'h0000;
    next_rev = next_running && !ctrl.route_volt && cur_ref[15];
    next_volt = (next_running && ctrl.route_volt) ? cur_ref : 16'h0000;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_freq_set <= 16'h0000;
      o_reverse <= 1'b0;
      o_ramp_sel <= RAMP_RST;
      o_volt_set <= 16'h0000;
      o_step <= 4'h0;
      o_running <= 1'b0;
    end else begin
      o_freq_set <= next_freq;
      o_reverse <= next_rev;
      o_ramp_sel <= ramp_mem[step];
      o_volt_set <= next_volt;
      o_step <= step;
      o_running <= next_running;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence pwr_back;
    state == ST_PWR ##0 !i_power_fail;
  endsequence

  rev_dir_a: assert property (state == ST_RUN && !ctrl.route_volt && cur_ref[15]
    |=> o_reverse && o_freq_set != 16'h0000) else $error("reverse not driven");
  stop_mode_a: assert property (pass_end && !ctrl.route_volt && ctrl.mode == EOC_STOP
    |=> state == ST_IDLE && step == 4'h0 ##1 !o_running) else $error("mode 0 did not stop");
  hold_mode_a: assert property (state == ST_HOLD && !i_stop_cmd && !i_power_fail
    |=> state == ST_HOLD && step == LAST_STEP && $stable(elapsed)) else $error("hold lost");
  repeat_mode_a: assert property (pass_end && (ctrl.mode == EOC_REPEAT || ctrl.route_volt)
    |=> state == ST_RUN && step == 4'h0 && elapsed == 16'h0000) else $error("no repeat");
  pwr_resume_a: assert property (pwr_back ##0 ctrl.ret_pwr
    |=> step == $past(pl_step) && elapsed == $past(pl_elapsed)) else $error("no resume");
  pwr_restart_a: assert property (pwr_back ##0 !ctrl.ret_pwr
    |=> step == 4'h0 && elapsed == 16'h0000) else $error("no restart after power");
  stop_keep_a: assert property (state == ST_IDLE && i_run_cmd && !i_stop_cmd
    && !i_power_fail && ctrl.ret_stop |=> state == ST_RUN && $stable(step))
    else $error("stop position lost");
  stop_restart_a: assert property (state == ST_IDLE && i_run_cmd && !i_stop_cmd
    && !i_power_fail && !ctrl.ret_stop |=> step == 4'h0 && elapsed == 16'h0000)
    else $error("start not from step zero");
  step_adv_a: assert property (step_done && step != LAST_STEP && !i_stop_cmd
    && !i_power_fail |=> step == $past(step) + 4'h1 && elapsed == 16'h0000)
    else $error("step advance wrong");
  tick_count_a: assert property (state == ST_RUN && tick && !step_done
    && !i_stop_cmd && !i_power_fail |=> elapsed == $past(elapsed) + 16'h0001)
    else $error("elapsed count wrong");

endmodule

`default_nettype wire

/* verification/drive_side_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Run/stop command logic and signed speed target of the drive
// ---------------------------------------------------------------
module drive_side_model (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic i_run_req, // Bench asks for a start
  input wire logic i_stop_req, // Bench asks for a stop
  input wire logic i_loss, // Bench cuts the supply
  input wire logic [15:0] i_freq_set, // Speed magnitude from sequencer
  input wire logic i_reverse, // Direction from sequencer
  output logic o_run_cmd, // Start pulse
  output logic o_stop_cmd, // Stop pulse
  output logic o_power_fail, // Supply lost level
  output logic signed [16:0] o_speed // Signed speed the ramp heads for
);
  // Commands leave a register so they change just after an edge, like real control logic
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_run_cmd <= 1'b0;
      o_stop_cmd <= 1'b0;
      o_power_fail <= 1'b0;
    end else begin
      o_run_cmd <= i_run_req;
      o_stop_cmd <= i_stop_req;
      o_power_fail <= i_loss;
    end
  end

  // Ramp target: magnitude with the sign taken from the direction bit
  assign o_speed = i_reverse ? -$signed({1'b0, i_freq_set}) : $signed({1'b0, i_freq_set});
endmodule

`default_nettype wire

/* verification/test_step_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin \
  compares++; \
  if ((gt) !== (ex)) begin \
    fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); \
  end \
end

module test_step_sequencer;
  import step_seq_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, run_req, stop_req, loss;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, run_cmd, stop_cmd, power_fail, reverse, running;
  logic [15:0] freq_set, volt_set;
  logic [1:0] ramp_sel;
  logic [3:0] step;
  logic signed [16:0] speed;
  int fail_count, compares, cyc, i;

  // ---------------------------------------------------------------
  // Clock, design and drive side
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Short tick keeps a full pass to a few dozen cycles
  step_sequencer #(.TENTH_S_CYCLES(4)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_run_cmd(run_cmd),
    .i_stop_cmd(stop_cmd), .i_power_fail(power_fail), .o_freq_set(freq_set),
    .o_reverse(reverse), .o_ramp_sel(ramp_sel), .o_volt_set(volt_set), .o_step(step),
    .o_running(running));

  drive_side_model partner (.i_clk(clk), .i_rst_n(rst_n), .i_run_req(run_req),
    .i_stop_req(stop_req), .i_loss(loss), .i_freq_set(freq_set), .i_reverse(reverse),
    .o_run_cmd(run_cmd), .o_stop_cmd(stop_cmd), .o_power_fail(power_fail), .o_speed(speed));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    // A slave that never answers is a mismatch, not a silent pass
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[FAIL] apb ready at %0h exp 1 got timeout", a);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] rq);
    logic re;
    apb(1'b0, a, 32'h0000_0000, rq, re);
  endtask

  // Command pulse through the drive side: 0 start, 1 stop
  task automatic send(input logic stop);
    if (stop) stop_req <= 1'b1;
    else run_req <= 1'b1;
    @(posedge clk);
    run_req <= 1'b0;
    stop_req <= 1'b0;
  endtask

  // Bounded wait: 0 running, 1 running at step s, 2 stopped
  task automatic wait_for(input int what, input logic [3:0] s);
    int n;
    n = 0;
    while (!((what == 0 && running === 1'b1) || (what == 2 && running === 1'b0) ||
             (what == 1 && running === 1'b1 && step === s)) && n < 3000) begin
      n++;
      @(posedge clk);
    end
    if (n >= 3000) begin
      fail_count++;
      $display("[FAIL] wait %0d exp done got timeout", what);
    end
  endtask

  // Alternating signs, last step at full-scale reverse
  function automatic logic [15:0] ref_of(input int k);
    if (k == 15) return 16'hFC18;
    if (k % 2 == 0) return 16'(-(k * 50 + 100));
    return 16'(k * 50 + 100);
  endfunction

  // Hang guard: a whole run needs about a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      final_report;
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, run_req, stop_req, loss} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fail_count = 0;
    compares = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CTRL_OFS, q);
    `CHK("ctrl reset", 32'h0000_0000, q);
    rd(STATUS_OFS, q);
    `CHK("status reset", 32'h0000_0000, q);
    rd(TIME_BASE + 12'h01C, q);
    `CHK("time reset", 32'h0000_0000, q);
    rd(RAMP_BASE + 12'h01C, q);
    `CHK("ramp reset", 32'h0000_0000, q);
    apb(1'b0, 12'h100, 32'h0000_0000, q, e);
    `CHK("unmapped err", 1'b1, e);
    apb(1'b1, STATUS_OFS, 32'h0000_0001, q, e);
    `CHK("status write err", 1'b1, e);
    for (i = 0; i < 16; i++) begin
      wr(REF_BASE + 12'(4 * i), {16'h0000, ref_of(i)});
      wr(TIME_BASE + 12'(4 * i), 32'h0000_0001);
      wr(RAMP_BASE + 12'(4 * i), 32'(i % 4));
    end
    rd(TIME_BASE + 12'h03C, q);
    `CHK("time readback", 32'h0000_0001, q);
    // Stop mode: one pass, then idle at step zero
    send(1'b0);
    wait_for(0, 4'h0);
    `CHK("step0 speed", 16'h0064, freq_set);
    `CHK("step0 reverse", 1'b1, reverse);
    `CHK("step0 signed", -17'sd100, speed);
    wait_for(1, 4'h1);
    `CHK("step1 speed", 16'h0096, freq_set);
    `CHK("step1 forward", 1'b0, reverse);
    `CHK("step1 ramp", 2'h1, ramp_sel);
    wait_for(2, 4'h0);
    repeat (20) @(posedge clk);
    `CHK("stop mode idle", 1'b0, running);
    `CHK("stop mode step", 4'h0, step);
    // Hold mode: last step stands
    wr(CTRL_OFS, 32'h0000_0002);
    send(1'b0);
    wait_for(1, 4'hF);
    repeat (40) @(posedge clk);
    `CHK("hold running", 1'b1, running);
    `CHK("hold step", 4'hF, step);
    `CHK("hold speed", 16'h03E8, freq_set);
    `CHK("hold reverse", 1'b1, reverse);
    `CHK("hold ramp", 2'h3, ramp_sel);
    rd(STATUS_OFS, q);
    `CHK("hold state", 2'h2, q[5:4]);
    send(1'b1);
    wait_for(2, 4'h0);
    // Repeat mode: wraps to step zero until stopped
    wr(CTRL_OFS, 32'h0000_0004);
    send(1'b0);
    wait_for(1, 4'hF);
    wait_for(1, 4'h0);
    wait_for(1, 4'h1);
    `CHK("repeat next pass", 1'b1, running);
    send(1'b1);
    wait_for(2, 4'h0);
    `CHK("repeat stopped", 1'b0, running);
    // Voltage route, stop mode set but not applied
    wr(CTRL_OFS, 32'h0000_0001);
    send(1'b0);
    wait_for(0, 4'h0);
    `CHK("volt value", ref_of(0), volt_set);
    `CHK("volt freq zero", 16'h0000, freq_set);
    `CHK("volt no reverse", 1'b0, reverse);
    repeat (100) @(posedge clk);
    `CHK("volt keeps running", 1'b1, running);
    send(1'b1);
    wait_for(2, 4'h0);
    // Stop retention on, then off; step 3 made long
    wr(TIME_BASE + 12'h00C, 32'h0000_0032);
    wr(CTRL_OFS, 32'h0000_0024);
    send(1'b0);
    wait_for(1, 4'h3);
    send(1'b1);
    wait_for(2, 4'h0);
    send(1'b0);
    wait_for(0, 4'h0);
    `CHK("stop retained step", 4'h3, step);
    send(1'b1);
    wait_for(2, 4'h0);
    wr(CTRL_OFS, 32'h0000_0004);
    send(1'b0);
    wait_for(0, 4'h0);
    `CHK("stop fresh step", 4'h0, step);
    send(1'b1);
    wait_for(2, 4'h0);
    // Power-loss retention on, then off
    wr(CTRL_OFS, 32'h0000_0014);
    send(1'b0);
    wait_for(1, 4'h3);
    loss <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("loss speed", 16'h0000, freq_set);
    `CHK("loss running", 1'b0, running);
    loss <= 1'b0;
    wait_for(0, 4'h0);
    `CHK("loss retained step", 4'h3, step);
    wr(CTRL_OFS, 32'h0000_0004);
    loss <= 1'b1;
    repeat (10) @(posedge clk);
    loss <= 1'b0;
    wait_for(0, 4'h0);
    `CHK("loss fresh step", 4'h0, step);
    send(1'b1);
    wait_for(2, 4'h0);
    // Elapsed counter in seconds, then in hours
    wr(TIME_BASE, 32'h0000_0064);
    wr(CTRL_OFS, 32'h0000_0000);
    send(1'b0);
    wait_for(0, 4'h0);
    repeat (40) @(posedge clk);
    rd(ELAPSED_OFS, q);
    `CHK("elapsed seconds", 1'b1, (q >= 32'd9 && q <= 32'd12));
    send(1'b1);
    wait_for(2, 4'h0);
    wr(CTRL_OFS, 32'h0000_0008);
    send(1'b0);
    wait_for(0, 4'h0);
    repeat (40) @(posedge clk);
    rd(ELAPSED_OFS, q);
    `CHK("elapsed hours", 32'h0000_0000, q);
    send(1'b1);
    wait_for(2, 4'h0);
    final_report;
  end
endmodule

`default_nettype wire
